// File: apo_pkg.sv
package apo_pkg;

   // Converter word and pipeline figures.
   localparam int CODE_W  = 14;
   localparam int LATENCY = 10;

   // Register map, byte addresses of 32-bit words.
   localparam int          ADDR_W         = 4;
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_STATUS    = 4'h4;
   localparam logic [3:0]  ADDR_LAST_WORD = 4'h8;
   localparam logic [3:0]  ADDR_COUNT     = 4'hC;

   // Control register fields and value after reset (every control input reads low).
   localparam int          CTRL_SLEEP_BIT = 0;
   localparam int          CTRL_TWOS_BIT  = 1;
   localparam int          CTRL_HIZ_BIT   = 2;
   localparam int          CTRL_W         = 3;
   localparam logic [2:0]  CTRL_RESET     = 3'h0;

   // Status register fields.
   localparam int          STAT_VALID_BIT  = 0;
   localparam int          STAT_ASLEEP_BIT = 1;

   // Bus responses.
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// File: apo_pipe.sv
// Latency chain: one stage per convert edge, flushed as a whole on power-down.
module apo_pipe
   import apo_pkg::*;
#(
   parameter int WIDTH = CODE_W,
   parameter int DEPTH = LATENCY
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             shift_en,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid
);

   logic [WIDTH-1:0] data_q  [DEPTH];
   logic [WIDTH-1:0] src_d   [DEPTH];
   logic [DEPTH-1:0] src_v;
   logic [DEPTH-1:0] valid_q;

   // Stage sources: the input feeds stage 0, each stage feeds the next.
   assign src_d[0] = in_data;
   assign src_v[0] = in_valid;

   genvar g;
   for (g = 0; g < DEPTH; g++) begin : stage
      logic [WIDTH-1:0] next_data;
      logic             next_valid;

      // Stage 0 takes the input instead, so the links start one stage in, at stage 1.
      if (g > 0) begin : link
         assign src_d[g] = data_q[g-1];
         assign src_v[g] = valid_q[g-1];
      end

      // Data only moves on a convert edge; a flush drops every valid mark at once.
      always_comb begin
         next_data  = data_q[g];
         next_valid = valid_q[g];
         if (flush) begin
            next_valid = 1'b0;
         end else if (shift_en) begin
            next_data  = src_d[g];
            next_valid = src_v[g];
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            data_q[g]  <= '0;
            valid_q[g] <= 1'b0;
         end else begin
            data_q[g]  <= next_data;
            valid_q[g] <= next_valid;
         end
      end
   end

   assign out_data  = data_q[DEPTH-1];
   assign out_valid = valid_q[DEPTH-1];

endmodule

// File: apo_adc_port.sv
// Notes on behaviour
// - A conversion starts only on each rising edge of the convert clock.
// - With two's complement off, output words use straight offset binary.
// - With two's complement selected, output words use binary two's complement.
// - Output-disable high floats the data outputs; low drives them.
// - Power-down high stops conversion; low means normal converting operation.
// - A data-valid strobe goes high while the output word holds a sample.
// - The first data pin carries the result MSB, bit 13.
// - The last data pin carries bit 0; pins between descend in order.
// - Control inputs left alone read as logic low.
// - A sample's word appears ten convert edges after the edge capturing it.
module apo_adc_port
   import apo_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Convert clock pin and raw quantizer code, both from outside this domain.
   input  wire logic              conv_clk,
   input  wire logic [CODE_W-1:0] raw_code,
   // Parallel output: bit 13 is the MSB pin, bit 0 the LSB pin.
   output logic      [CODE_W-1:0] sample_word,
   output logic                   sample_oe_n,
   output logic                   sample_valid,
   // AXI4-Lite slave.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // Decodes a word address to "this register exists".
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_LAST_WORD) || (a == ADDR_COUNT);
   endfunction

   // ---------------- Pin synchronisers ----------------
   logic              clk_s1, clk_s2, clk_s3;
   logic [CODE_W-1:0] code_s1, code_s2;
   logic              conv_edge;

   // The first stage is read only by the second; the edge detector looks at stages two and three.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_s1  <= 1'b0;
         clk_s2  <= 1'b0;
         clk_s3  <= 1'b0;
         code_s1 <= '0;
         code_s2 <= '0;
      end else begin
         clk_s1  <= conv_clk;
         clk_s2  <= clk_s1;
         clk_s3  <= clk_s2;
         code_s1 <= raw_code;
         code_s2 <= code_s1;
      end
   end

   // Only a rising convert edge counts; the falling edge starts nothing.
   assign conv_edge = clk_s2 & ~clk_s3;

   // ---------------- Control register ----------------
   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic              sleep_req, twos_comp_sel, out_hiz;

   assign sleep_req     = ctrl[CTRL_SLEEP_BIT];
   assign twos_comp_sel = ctrl[CTRL_TWOS_BIT];
   assign out_hiz       = ctrl[CTRL_HIZ_BIT];

   // ---------------- Conversion pipeline ----------------
   logic [CODE_W-1:0] pipe_data;
   logic              pipe_valid;
   logic              capture;

   // While asleep no sample enters and the chain is emptied, so waking starts clean.
   assign capture = conv_edge & ~sleep_req;

   apo_pipe #(
      .WIDTH (CODE_W),
      .DEPTH (LATENCY)
   ) u_pipe (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .shift_en  (capture),
      .flush     (sleep_req),
      .in_data   (code_s2),
      .in_valid  (1'b1),
      .out_data  (pipe_data),
      .out_valid (pipe_valid)
   );

   // ---------------- Output stage ----------------
   logic [CODE_W-1:0] next_word;
   logic              next_valid, next_oe_n;
   logic [31:0]       sample_count, next_count;

   // The word loads on the edge that pushes a sample out of the last stage.
   always_comb begin
      next_word  = sample_word;
      next_valid = sample_valid;
      next_oe_n  = out_hiz;
      next_count = sample_count;
      if (sleep_req) begin
         next_valid = 1'b0;
      end else if (capture) begin
         next_valid = pipe_valid;
         if (pipe_valid) begin
            next_count = sample_count + 32'h1;
            // Offset binary passes as is; two's complement only flips the MSB.
            next_word  = pipe_data;
            if (twos_comp_sel) begin
               next_word[CODE_W-1] = ~pipe_data[CODE_W-1];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_word  <= '0;
         sample_valid <= 1'b0;
         sample_oe_n  <= 1'b0;
         sample_count <= 32'h0;
      end else begin
         sample_word  <= next_word;
         sample_valid <= next_valid;
         sample_oe_n  <= next_oe_n;
         sample_count <= next_count;
      end
   end

   // ---------------- AXI4-Lite write ----------------
   logic              aw_held, w_held, next_aw_held, next_w_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0]       w_data, next_w_data;
   logic [3:0]        w_strb, next_w_strb;
   logic              next_bvalid;
   logic [1:0]        next_bresp;

   // Address and data are held separately so either may arrive first; the write lands once both are in.
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_ctrl    = ctrl;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (aw_addr == ADDR_CTRL && w_strb[0]) begin
            next_ctrl = w_data[CTRL_W-1:0];
         end
      end
   end

   // Ready drops while a half is held, so a second write waits for the first response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl          <= CTRL_RESET;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         ctrl          <= next_ctrl;
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         aw_addr       <= next_aw_addr;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= ~next_aw_held & ~next_bvalid;
         s_axi_wready  <= ~next_w_held & ~next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
      end
   end

   // ---------------- AXI4-Lite read ----------------
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        next_rvalid;

   // Status shows the live strobe and the sleep state; unmapped reads return zero with an error.
   always_comb begin
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      next_rvalid = s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         next_rdata  = 32'h0;
         unique case (s_axi_araddr)
            ADDR_CTRL:      next_rdata[CTRL_W-1:0] = ctrl;
            ADDR_STATUS: begin
               next_rdata[STAT_VALID_BIT]  = sample_valid;
               next_rdata[STAT_ASLEEP_BIT] = sleep_req;
            end
            ADDR_LAST_WORD: next_rdata[CODE_W-1:0] = sample_word;
            ADDR_COUNT:     next_rdata = sample_count;
            default:        next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ---------------- Assertions ----------------
   localparam int WAKE_LAT = LATENCY + 1;
   logic [4:0] wake_edges;

   // Counts convert edges since the last wake, saturating; checks the latency only.
   always_ff @(posedge aclk) begin
      if (!aresetn || sleep_req) begin
         wake_edges <= 5'h0;
      end else if (conv_edge && wake_edges != 5'h1F) begin
         wake_edges <= wake_edges + 5'h1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_word_on_edge: assert property ($changed(sample_word) |-> $past(capture))
      else $error("Output word changed without a rising convert edge.");
   a_offset_coding: assert property (capture && pipe_valid && !twos_comp_sel |=>
      sample_word == $past(pipe_data))
      else $error("Offset binary word differs from the pipeline result.");
   a_twos_coding: assert property (capture && pipe_valid && twos_comp_sel |=>
      sample_word == {~$past(pipe_data[CODE_W-1]), $past(pipe_data[CODE_W-2:0])})
      else $error("Two's complement word is not the MSB-flipped result.");
   a_float_follows: assert property (##1 sample_oe_n == $past(out_hiz))
      else $error("Output enable does not follow the float control.");
   a_sleep_quiet: assert property (sleep_req |=> !sample_valid && $stable(sample_word))
      else $error("Output moved while powered down.");
   a_valid_marks: assert property ($rose(sample_valid) |-> $past(capture && pipe_valid))
      else $error("Valid strobe rose without a sample leaving the pipeline.");
   a_msb_pin: assert property (capture && pipe_valid && !twos_comp_sel |=>
      sample_word[CODE_W-1] == $past(pipe_data[CODE_W-1]))
      else $error("MSB pin does not carry result bit 13.");
   a_lsb_pin: assert property (capture && pipe_valid |=> sample_word[0] == $past(pipe_data[0]))
      else $error("LSB pin does not carry result bit 0.");
   a_ctrl_low: assert property ($rose(aresetn) |-> ctrl == CTRL_RESET)
      else $error("Control inputs do not read low after reset.");
   a_latency_ten: assert property ($rose(sample_valid) |-> wake_edges == WAKE_LAT)
      else $error("First valid word did not appear ten edges after capture.");

   c_twos_sample: cover property (capture && pipe_valid && twos_comp_sel);
   c_float: cover property ($rose(sample_oe_n));
   c_sleep_wake: cover property ($fell(sleep_req) ##[1:300] $rose(sample_valid));
   c_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);

endmodule

// File: apo_capture_model.sv
// Capture logic on the far side, clocked from the same convert clock as the converter.
module apo_capture_model
   import apo_pkg::*;
(
   input  wire logic              conv_clk,
   input  wire logic [CODE_W-1:0] sample_word,
   input  wire logic              sample_oe_n,
   input  wire logic              sample_valid,
   output logic      [CODE_W-1:0] got_word,
   output int                     got_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // Held state starts known, so a count that never moves cannot hide behind unknowns.
   logic [CODE_W-1:0] word_q  = '0;
   int                count_q = 0;

   // A floating bus or a stale word would corrupt the stream, so only a valid driven word is taken.
   always @(posedge conv_clk) begin
      if (sample_valid === 1'b1 && sample_oe_n === 1'b0) begin
         word_q  <= sample_word;
         count_q <= count_q + 1;
      end
   end

   // One driver for each output.
   assign got_word = word_q;
   assign got_n    = count_q;
endmodule

// File: adc_parallel_output_port_tb.sv
module adc_parallel_output_port_tb
   import apo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              aclk, aresetn, conv_clk;
   logic [CODE_W-1:0] raw_code, sample_word, got_word;
   logic              sample_oe_n, sample_valid;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic [1:0]        bresp, rresp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int                miscompares, checks_done, got_n;

   apo_adc_port uut (
      .aclk(aclk), .aresetn(aresetn), .conv_clk(conv_clk), .raw_code(raw_code),
      .sample_word(sample_word), .sample_oe_n(sample_oe_n), .sample_valid(sample_valid),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   apo_capture_model far (
      .conv_clk(conv_clk), .sample_word(sample_word), .sample_oe_n(sample_oe_n),
      .sample_valid(sample_valid), .got_word(got_word), .got_n(got_n));

   // Free-running 10 MHz system clock.
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task wrap_up;
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task too_long;
      chk("bus answer", 32'h1, 32'h0);
      wrap_up;
   endtask

   // Write with both halves offered together; each is released at the edge where it is taken.
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
      int k;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (k == 50) too_long;
      chk("write response", 32'(exp), 32'(bresp));
      bready <= 1'b0;
   endtask

   task rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
      int k;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (k == 50) too_long;
      chk("read data", exp, rdata);
      chk("read response", 32'(exp_resp), 32'(rresp));
      rready <= 1'b0;
   endtask

   function automatic logic [CODE_W-1:0] pat(input int i);
      pat = (i == 0) ? 14'h2000 : (i == 1) ? 14'h0001 : 14'(i * 16'h0A53);
   endfunction

   // The code is set a cycle ahead of the rise so that it is steady when the converter samples it.
   task pulse(input logic [CODE_W-1:0] c);
      @(posedge aclk);
      raw_code <= c;
      @(posedge aclk);
      conv_clk <= 1'b1;
      repeat (3) @(posedge aclk);
      conv_clk <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   // Feeds n samples; the word of sample i must appear after sample i+LATENCY is started.
   task stream(input int n, input logic [CODE_W-1:0] flip, input bit fresh);
      for (int i = 0; i < n; i++) begin
         pulse(pat(i));
         if (fresh && i == LATENCY - 1) chk("early valid", 32'h0, 32'(sample_valid));
         if (i >= LATENCY) begin
            chk("sample word", 32'(pat(i - LATENCY) ^ flip), 32'(sample_word));
            chk("sample valid", 32'h1, 32'(sample_valid));
         end
      end
   endtask

   task t_reset;
      chk("valid at reset", 32'h0, 32'(sample_valid));
      chk("enable at reset", 32'h0, 32'(sample_oe_n));
      rd(ADDR_CTRL, 32'(CTRL_RESET), RESP_OKAY);
   endtask

   task t_offset;
      stream(12, 14'h0000, 1'b1);
      chk("captured word", 32'(pat(0)), 32'(got_word));
      rd(ADDR_LAST_WORD, 32'(pat(1)), RESP_OKAY);
   endtask

   task t_twos;
      wr(ADDR_CTRL, 32'h2, RESP_OKAY);
      stream(12, 14'h2000, 1'b0);
   endtask

   task t_float;
      int n;
      wr(ADDR_CTRL, 32'h4, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("float on", 32'h1, 32'(sample_oe_n));
      n = got_n;
      pulse(14'h3FFF);
      chk("captures while float", 32'(n), 32'(got_n));
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("float off", 32'h0, 32'(sample_oe_n));
   endtask

   task t_sleep;
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("valid asleep", 32'h0, 32'(sample_valid));
      rd(ADDR_STATUS, 32'h2, RESP_OKAY);
      repeat (3) pulse(14'h3FFF);
      chk("valid after sleep edges", 32'h0, 32'(sample_valid));
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      stream(12, 14'h0000, 1'b1);
   endtask

   task t_bus;
      wr(4'h2, 32'h7, RESP_SLVERR);
      rd(4'h2, 32'h0, RESP_SLVERR);
      rd(ADDR_CTRL, 32'h0, RESP_OKAY);
      // Two outputs in each fresh stream, twelve in the full one, one while floating.
      rd(ADDR_COUNT, 32'h11, RESP_OKAY);
      rd(ADDR_STATUS, 32'h1, RESP_OKAY);
   endtask

   // Inputs get values at time zero; reset is held for 10 edges.
   initial begin
      miscompares = 0;
      checks_done = 0;
      aresetn = 1'b0;
      conv_clk = 1'b0;
      raw_code = '0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_reset;
      t_offset;
      t_twos;
      t_float;
      t_sleep;
      t_bus;
      wrap_up;
   end
endmodule
